// [core/timer2_mode_engine.sv]
// Sixteen-bit timer with capture, auto-reload, up/down, baud and clock-out modes.
// Assumes control bits are held by a register file outside and pins are synchronous.

`default_nettype none

module timer2_mode_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control bits
  input wire logic runControl,
  input wire logic counterSelect,
  input wire logic captureReloadSelect,
  input wire logic externalEdgeEnable,
  input wire logic rxBaudSelect,
  input wire logic txBaudSelect,
  input wire logic downCountEnable,
  input wire logic clockOutEnable,
  input wire logic [1:0] compareModeField,
  // Clock control
  input wire logic [timer2_pkg::TPS_W-1:0] prescaleValue,
  input wire logic fastMode,
  input wire logic fastPrescaleApply,
  // Software access to count and reload
  input wire logic countWrite,
  input wire logic [timer2_pkg::COUNT_W-1:0] countWriteData,
  input wire logic reloadWrite,
  input wire logic [timer2_pkg::COUNT_W-1:0] reloadWriteData,
  input wire logic overflowFlagClear,
  input wire logic externalFlagClear,
  // Pins
  input wire logic captureDirectionPin,
  input wire logic clockPinIn,
  output logic clockOutPin,
  output logic clockOutOeN,
  // Serial port and other timer
  input wire logic timer1Overflow,
  output logic rxBaudPulse,
  output logic txBaudPulse,
  // Status
  output logic [timer2_pkg::COUNT_W-1:0] count,
  output logic [timer2_pkg::COUNT_W-1:0] reload,
  output logic overflowFlag,
  output logic externalFlag,
  output logic interruptRequest
);
  timer2_pkg::timer_mode_t mode;
  logic prescaleTick;
  logic pinFall;
  logic capFall;
  logic exEdge;
  logic tick;
  logic countDown;
  logic rollover;
  logic clockOutMode;
  logic [timer2_pkg::COUNT_W-1:0] next_count;
  logic [timer2_pkg::COUNT_W-1:0] next_reload;
  logic next_overflowFlag;
  logic next_externalFlag;
  logic next_clockOutPin;
  logic next_clockOutOeN;
  logic next_rxBaudPulse;
  logic next_txBaudPulse;
  logic next_interruptRequest;

  // Mode decode; baud selects and clock-out outrank capture/reload select
  function automatic timer2_pkg::timer_mode_t decodeMode(
    input logic run,
    input logic baud,
    input logic clkOut,
    input logic capSel,
    input logic down_count_enable
  );
    if (!run) begin
      decodeMode = timer2_pkg::MODE_OFF;
    end else if (baud) begin
      decodeMode = timer2_pkg::MODE_BAUD;
    end else if (clkOut) begin
      decodeMode = timer2_pkg::MODE_CLOCK_OUT;
    end else if (capSel) begin
      decodeMode = timer2_pkg::MODE_CAPTURE;
    end else if (down_count_enable) begin
      decodeMode = timer2_pkg::MODE_RELOAD_UPDOWN;
    end else begin
      decodeMode = timer2_pkg::MODE_RELOAD_UP;
    end
  endfunction

  // Tick source: system clock through the prescaler
  timer2_prescaler prescaler (
    .clk(clk),
    .rst(rst),
    .prescaleValue(prescaleValue),
    .fastMode(fastMode),
    .fastPrescaleApply(fastPrescaleApply),
    .tick(prescaleTick)
  );

  // Falling edges on the external count pin
  timer2_fall_detect countEdge (
    .clk(clk),
    .rst(rst),
    .pin(clockPinIn),
    .fall(pinFall)
  );

  // Falling edges on the capture/direction pin
  timer2_fall_detect captureEdge (
    .clk(clk),
    .rst(rst),
    .pin(captureDirectionPin),
    .fall(capFall)
  );

  // Mode, tick and direction selection
  always_comb begin
    mode = decodeMode(runControl, rxBaudSelect || txBaudSelect,
      clockOutEnable && !counterSelect, captureReloadSelect, downCountEnable);
    clockOutMode = clockOutEnable && !counterSelect;
    exEdge = capFall && externalEdgeEnable;
    // With counter select clear, baud and clock-out step every clock so their rates follow the reload value
    if (!runControl) begin
      tick = 1'b0;
    end else if (counterSelect) begin
      tick = pinFall;
    end else if (mode == timer2_pkg::MODE_BAUD || clockOutMode) begin
      tick = 1'b1;
    end else begin
      tick = prescaleTick;
    end
    // Direction only follows the pin in up/down mode
    countDown = (mode == timer2_pkg::MODE_RELOAD_UPDOWN) && !captureDirectionPin;
  end

  // Count and reload pair next values
  always_comb begin
    next_count = count;
    next_reload = reload;
    rollover = 1'b0;
    if (countWrite) begin
      // Software load wins over this cycle's step
      next_count = countWriteData;
    end else if (tick) begin
      if (countDown) begin
        if (count == reload) begin
          next_count = timer2_pkg::COUNT_MAX;
          rollover = 1'b1;
        end else begin
          next_count = count - 16'h0001;
        end
      end else if (count == timer2_pkg::COUNT_MAX) begin
        rollover = 1'b1;
        if (mode == timer2_pkg::MODE_CAPTURE) begin
          next_count = timer2_pkg::COUNT_MIN;
        end else begin
          // Baud and clock-out share this same reload pair
          next_count = reload;
        end
      end else begin
        next_count = count + 16'h0001;
      end
    end
    // Pin-driven reload only in up-only auto-reload; baud mode ignores it
    if (exEdge && mode == timer2_pkg::MODE_RELOAD_UP && !countWrite) begin
      next_count = reload;
    end
    if (reloadWrite) begin
      next_reload = reloadWriteData;
    end
    // A capture in the same cycle as a reload write keeps the captured count
    if (exEdge && mode == timer2_pkg::MODE_CAPTURE) begin
      next_reload = count;
    end
  end

  // Flags, interrupt and pin next values
  always_comb begin
    // Clear first so a same-cycle hardware event still sets the flag
    next_overflowFlag = overflowFlag && !overflowFlagClear;
    next_externalFlag = externalFlag && !externalFlagClear;
    if (rollover && (mode == timer2_pkg::MODE_CAPTURE
        || mode == timer2_pkg::MODE_RELOAD_UP
        || mode == timer2_pkg::MODE_RELOAD_UPDOWN)) begin
      next_overflowFlag = 1'b1;
    end
    if (mode == timer2_pkg::MODE_RELOAD_UPDOWN) begin
      if (rollover) begin
        next_externalFlag = !externalFlag;
      end
    end else if (exEdge && (mode == timer2_pkg::MODE_CAPTURE
        || mode == timer2_pkg::MODE_RELOAD_UP
        || mode == timer2_pkg::MODE_BAUD)) begin
      next_externalFlag = 1'b1;
    end
    // External flag is a seventeenth bit in up/down mode, not an interrupt
    next_interruptRequest = overflowFlag
      || (externalFlag && mode != timer2_pkg::MODE_RELOAD_UPDOWN);
    // Clock-out toggles on each rollover, giving a 50% duty square wave
    next_clockOutPin = clockOutPin;
    if (clockOutMode && rollover) begin
      next_clockOutPin = !clockOutPin;
    end
    next_clockOutOeN = !clockOutMode;
    // Each serial direction takes this timer or the other timer's overflow
    next_rxBaudPulse = rxBaudSelect ? (rollover && mode == timer2_pkg::MODE_BAUD)
      : timer1Overflow;
    next_txBaudPulse = txBaudSelect ? (rollover && mode == timer2_pkg::MODE_BAUD)
      : timer1Overflow;
  end

  // State registers; down count enable lives outside and resets to zero there
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= timer2_pkg::COUNT_RESET;
      reload <= timer2_pkg::RELOAD_RESET;
      overflowFlag <= 1'b0;
      externalFlag <= 1'b0;
      interruptRequest <= 1'b0;
      clockOutPin <= timer2_pkg::PIN_IDLE;
      clockOutOeN <= 1'b1;
      rxBaudPulse <= 1'b0;
      txBaudPulse <= 1'b0;
    end else begin
      count <= next_count;
      reload <= next_reload;
      overflowFlag <= next_overflowFlag;
      externalFlag <= next_externalFlag;
      interruptRequest <= next_interruptRequest;
      clockOutPin <= next_clockOutPin;
      clockOutOeN <= next_clockOutOeN;
      rxBaudPulse <= next_rxBaudPulse;
      txBaudPulse <= next_txBaudPulse;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Capture copies the count seen at the edge
  a_capture_copy: assert property (
    (mode == timer2_pkg::MODE_CAPTURE && exEdge) |=> reload == $past(count))
    else $error("capture did not copy count");

  // Qualifying edge raises the external flag
  a_edge_sets_flag: assert property (
    (exEdge && (mode == timer2_pkg::MODE_CAPTURE || mode == timer2_pkg::MODE_BAUD))
      |=> externalFlag)
    else $error("external flag not set on edge");

  // Capture wraps to zero and flags overflow
  a_capture_wrap: assert property (
    (mode == timer2_pkg::MODE_CAPTURE && tick && !countWrite
      && count == timer2_pkg::COUNT_MAX)
      |=> (count == timer2_pkg::COUNT_MIN && overflowFlag))
    else $error("capture wrap wrong");

  // Up auto-reload loads the reload pair at overflow
  a_up_reload: assert property (
    (mode == timer2_pkg::MODE_RELOAD_UP && tick && !countWrite && !exEdge
      && count == timer2_pkg::COUNT_MAX)
      |=> (count == $past(reload) && overflowFlag))
    else $error("auto-reload overflow wrong");

  // Down count underflow loads all ones
  a_down_underflow: assert property (
    (countDown && tick && !countWrite && count == reload)
      |=> count == timer2_pkg::COUNT_MAX)
    else $error("underflow did not load max");

  // Up/down wrap toggles the external flag
  a_ext_toggle: assert property (
    (mode == timer2_pkg::MODE_RELOAD_UPDOWN && rollover && !externalFlagClear)
      |=> externalFlag != $past(externalFlag))
    else $error("external flag did not toggle");

  // No interrupt from the external flag in up/down mode
  a_updown_no_irq: assert property (
    (mode == timer2_pkg::MODE_RELOAD_UPDOWN && !overflowFlag) |=> !interruptRequest)
    else $error("interrupt raised in up/down mode");

  // Baud rollover leaves the overflow flag alone
  a_baud_no_flag: assert property (
    (mode == timer2_pkg::MODE_BAUD && rollover && !overflowFlag) |=> !overflowFlag)
    else $error("baud rollover set overflow flag");

  // Baud mode edge gives no reload
  a_baud_no_reload: assert property (
    (mode == timer2_pkg::MODE_BAUD && exEdge && !countWrite
      && count != timer2_pkg::COUNT_MAX)
      |=> (count == $past(count) || count == $past(count) + 16'h0001))
    else $error("baud edge changed count");

  // Clock-out pin toggles on every rollover
  a_clock_toggle: assert property (
    (clockOutMode && rollover) |=> clockOutPin != $past(clockOutPin))
    else $error("clock-out pin did not toggle");

  // A stopped timer holds its count
  a_stopped_hold: assert property (
    (!runControl && !countWrite) |=> count == $past(count))
    else $error("stopped timer moved");

  // Baud rollover reloads from the preset pair
  a_baud_reload: assert property (
    (mode == timer2_pkg::MODE_BAUD && tick && !countWrite
      && count == timer2_pkg::COUNT_MAX) |=> count == $past(reload))
    else $error("baud rollover did not reload");

  // Software preset of the reload pair lands unless a capture takes it
  a_reload_write: assert property (
    (reloadWrite && !(exEdge && mode == timer2_pkg::MODE_CAPTURE))
      |=> reload == $past(reloadWriteData))
    else $error("reload write lost");

  // Pin edge in up-only auto-reload forces the reload
  a_edge_reload: assert property (
    (mode == timer2_pkg::MODE_RELOAD_UP && exEdge && !countWrite)
      |=> count == $past(reload))
    else $error("pin edge did not reload");

  // Pin low in up/down mode steps the count down by one
  a_down_step: assert property (
    (countDown && tick && !countWrite && count != reload)
      |=> count == $past(count) - 16'h0001)
    else $error("down step wrong");

  // Baud rollover reaches the selected serial direction
  a_rx_baud_pulse: assert property (
    (rxBaudSelect && mode == timer2_pkg::MODE_BAUD && rollover) |=> rxBaudPulse)
    else $error("receive baud pulse missing");

  // A clear select hands the other timer's overflow through
  a_tx_follow: assert property (
    !txBaudSelect |=> txBaudPulse == $past(timer1Overflow))
    else $error("transmit pulse not from other timer");

  // Clock-out rollovers leave the overflow flag alone
  a_clkout_no_flag: assert property (
    (mode == timer2_pkg::MODE_CLOCK_OUT && rollover && !overflowFlag) |=> !overflowFlag)
    else $error("clock-out rollover set overflow flag");

  // Clock-out mode drives the shared pin
  a_clock_drive: assert property (
    clockOutMode |=> !clockOutOeN)
    else $error("clock-out pin not driven");
endmodule

`default_nettype wire

// [core/timer2_pkg.sv]
// Constants, reset values and mode codes for the sixteen-bit mode timer.
// Assumes a single 20 MHz clock; every control bit arrives as a plain port.
//
// Notes on behaviour
// - Capture mode counts up 0000H to FFFFH; wrap to zero sets overflow flag.
// - Capture mode, edge enabled: falling pin edge copies count into reload pair.
// - Capture mode: each qualifying falling pin edge sets the external flag.
// - Capture mode overflows every 65536 ticks of prescale value plus one clocks.
// - Fast mode prescales only with apply bit; compatibility mode doubles when set.
// - Down count enable resets to 0, so auto-reload counts upward.
// - Up auto-reload: at FFFFH set overflow flag and load reload pair.
// - Up auto-reload, edge enabled: falling pin edge forces reload, sets external flag.
// - Down count enable: pin high counts up, pin low counts down.
// - Up/down counting up with compare field 00B: overflow at FFFFH, flag, reload.
// - Counting down: at reload value set overflow flag and load FFFFH.
// - Up/down mode toggles external flag per wrap; it raises no interrupt.
// - Baud select bits pick baud mode; clear directions keep other timer's overflows.
// - Baud mode: high byte rollover reloads count from reload pair.
// - Baud rate equals overflow rate over 16, one count per clock.
// - Baud mode rollover sets no overflow flag and no interrupt.
// - Baud mode, edge enabled: falling edge sets external flag, no reload.
// - Baud and clock-out modes may run together on one reload pair.
// - Counter select clear, clock-out enabled: pin toggles each overflow.
// - Run control starts the timer when set and stops it when clear.
// - Clock-out frequency is clock over 2 times (65536 minus reload).
// - Clock-out mode rollovers raise no interrupt.
// - Minimum count 0000H, maximum FFFFH, boundary is the reload pair.
// - Counter select set: count falling edges on the count pin.

`default_nettype none

package timer2_pkg;
  localparam int COUNT_W = 16;
  localparam int TPS_W = 4;
  localparam logic [COUNT_W-1:0] COUNT_MIN = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] RELOAD_RESET = 16'h0000;
  localparam logic [TPS_W:0] PRESCALE_RESET = 5'h00;
  localparam logic [1:0] COMPARE_AT_MAX = 2'h0;
  localparam logic PIN_IDLE = 1'b1;

  // Operating mode decoded from the control bits
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_CAPTURE = 3'b001,
    MODE_RELOAD_UP = 3'b010,
    MODE_RELOAD_UPDOWN = 3'b011,
    MODE_BAUD = 3'b100,
    MODE_CLOCK_OUT = 3'b101
  } timer_mode_t;
endpackage

`default_nettype wire

// [core/timer2_prescaler.sv]
// Prescaler that turns the system clock into count ticks.
// Assumes the prescale value and mode bits are steady between writes.

`default_nettype none

module timer2_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic [timer2_pkg::TPS_W-1:0] prescaleValue,
  input wire logic fastMode,
  input wire logic fastPrescaleApply,
  // Tick out
  output logic tick
);
  logic [timer2_pkg::TPS_W:0] divCount;
  logic [timer2_pkg::TPS_W:0] next_divCount;
  logic [timer2_pkg::TPS_W:0] limit;

  // Divide limit: fast mode bypasses unless applied, compatibility doubles when applied
  always_comb begin
    if (fastMode && !fastPrescaleApply) begin
      limit = timer2_pkg::PRESCALE_RESET;
    end else if (!fastMode && fastPrescaleApply) begin
      limit = {prescaleValue, 1'b1};
    end else begin
      limit = {1'b0, prescaleValue};
    end
    tick = (divCount >= limit);
    next_divCount = tick ? timer2_pkg::PRESCALE_RESET : divCount + 5'h01;
  end

  // Divider register
  always_ff @(posedge clk) begin
    if (rst) begin
      divCount <= timer2_pkg::PRESCALE_RESET;
    end else begin
      divCount <= next_divCount;
    end
  end
endmodule

`default_nettype wire

// [core/timer2_fall_detect.sv]
// Falling edge detector for a pin already synchronous to clk.
// Idles high after reset so a pin already low at release gives one falling edge.

`default_nettype none

module timer2_fall_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and edge
  input wire logic pin,
  output logic fall
);
  logic prev;
  logic next_prev;

  // Edge is a one-cycle pulse on the first low sample
  always_comb begin
    next_prev = pin;
    fall = prev && !pin;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= timer2_pkg::PIN_IDLE;
    end else begin
      prev <= next_prev;
    end
  end
endmodule

`default_nettype wire

// [tb/timer2_pin_model.sv]
// Far-side model: capture/direction pin, external count pin, other timer.
// Assumes bench requests change just after a rising edge; pins idle high.

`default_nettype none

module timer2_pin_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests from the bench
  input wire logic capFallReq,
  input wire logic capHold,
  input wire logic capLevel,
  input wire logic cntFallReq,
  // Pins toward the timer
  output logic capPin,
  output logic cntPin,
  output logic t1Ovf
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] capLow;
  logic [1:0] cntLow;
  logic [2:0] t1Div;

  // Falls last two clocks so the timer sees one low sample at least
  always_ff @(posedge clk) begin
    if (rst) begin
      capLow <= 2'h0;
      cntLow <= 2'h0;
      t1Div <= 3'h0;
    end else begin
      capLow <= capFallReq ? 2'h2 : ((capLow != 2'h0) ? capLow - 2'h1 : 2'h0);
      cntLow <= cntFallReq ? 2'h2 : ((cntLow != 2'h0) ? cntLow - 2'h1 : 2'h0);
      t1Div <= t1Div + 3'h1;
    end
  end

  // Held level serves as count direction; otherwise pulled high
  assign capPin = capHold ? capLevel : (capLow == 2'h0);
  assign cntPin = (cntLow == 2'h0);
  assign t1Ovf = (t1Div == 3'h7);
endmodule

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the sixteen-bit mode timer.
// Assumes the pin model above; the count pin wire is resolved here.

`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, runControl = 1'b0, counterSelect = 1'b0;
  logic captureReloadSelect = 1'b0, externalEdgeEnable = 1'b0, rxBaudSelect = 1'b0;
  logic txBaudSelect = 1'b0, downCountEnable = 1'b0, clockOutEnable = 1'b0;
  logic [1:0] compareModeField = 2'h0;
  logic [3:0] prescaleValue = 4'h0;
  logic fastMode = 1'b1, fastPrescaleApply = 1'b0, countWrite = 1'b0, reloadWrite = 1'b0;
  logic [15:0] countWriteData = 16'h0000, reloadWriteData = 16'h0000;
  logic overflowFlagClear = 1'b0, externalFlagClear = 1'b0;
  logic capReq = 1'b0, capHold = 1'b0, capLevel = 1'b1, cntReq = 1'b0;
  wire captureDirectionPin, clockPinIn, cntPin, timer1Overflow;
  wire clockOutPin, clockOutOeN, rxBaudPulse, txBaudPulse;
  wire overflowFlag, externalFlag, interruptRequest;
  wire [15:0] count, reload;
  int failures = 0, samplesChecked = 0, cyc, rx, tx, co;
  int fastT[4] = '{1, 1, 0, 0}, applyT[4] = '{0, 1, 0, 1}, divT[4] = '{1, 4, 4, 8};

  always #25 clk = ~clk;
  // Shared pin: timer drives it while its enable is low
  assign clockPinIn = clockOutOeN ? cntPin : clockOutPin;

  timer2_mode_engine u_dut (.clk, .rst, .runControl, .counterSelect, .captureReloadSelect,
    .externalEdgeEnable, .rxBaudSelect, .txBaudSelect, .downCountEnable, .clockOutEnable,
    .compareModeField, .prescaleValue, .fastMode, .fastPrescaleApply, .countWrite,
    .countWriteData, .reloadWrite, .reloadWriteData, .overflowFlagClear, .externalFlagClear,
    .captureDirectionPin, .clockPinIn, .clockOutPin, .clockOutOeN, .timer1Overflow,
    .rxBaudPulse, .txBaudPulse, .count, .reload, .overflowFlag, .externalFlag,
    .interruptRequest);

  timer2_pin_model u_pins (.clk, .rst, .capFallReq(capReq), .capHold, .capLevel,
    .cntFallReq(cntReq), .capPin(captureDirectionPin), .cntPin, .t1Ovf(timer1Overflow));

  // Inputs always move 2 ns after the edge so sampling never races
  task automatic step(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Rate checks allow a tick of prescaler phase either way
  task automatic cmpIn(input int got, input int lo, input int hi);
    samplesChecked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wrCount(input logic [15:0] v);
    countWrite = 1'b1;
    countWriteData = v;
    step();
    countWrite = 1'b0;
  endtask

  task automatic wrReload(input logic [15:0] v);
    reloadWrite = 1'b1;
    reloadWriteData = v;
    step();
    reloadWrite = 1'b0;
  endtask

  task automatic clrFlags();
    overflowFlagClear = 1'b1;
    externalFlagClear = 1'b1;
    step();
    overflowFlagClear = 1'b0;
    externalFlagClear = 1'b0;
    step(2);
  endtask

  task automatic capFall();
    capReq = 1'b1;
    step();
    capReq = 1'b0;
    step(5);
  endtask

  task automatic cntFall();
    cntReq = 1'b1;
    step();
    cntReq = 1'b0;
    step(5);
  endtask

  // Counts baud pulses and clock-out toggles over a window
  task automatic watch(input int n);
    logic prev;
    rx = 0;
    tx = 0;
    co = 0;
    prev = clockOutPin;
    repeat (n) begin
      step();
      rx += (rxBaudPulse === 1'b1);
      tx += (txBaudPulse === 1'b1);
      co += (clockOutPin !== prev);
      prev = clockOutPin;
    end
  endtask

  task automatic waitOf();
    cyc = 0;
    while (overflowFlag !== 1'b1) begin
      step();
      cyc++;
      if (cyc > 2000) begin
        failures++;
        break;
      end
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    step(2);
    rst = 1'b0;
    cmp(count, 16'h0000);
    cmp(reload, 16'h0000);
    cmp({overflowFlag, externalFlag, interruptRequest}, 16'h0000);
    cmp({clockOutPin, clockOutOeN}, 16'h0003);
    $display("test reset done");
    // Capture mode counting pin falls, so every count is deterministic
    captureReloadSelect = 1'b1;
    counterSelect = 1'b1;
    externalEdgeEnable = 1'b1;
    runControl = 1'b1;
    wrCount(16'hFFFE);
    cntFall();
    cmp(count, 16'hFFFF);
    cntFall();
    cmp(count, 16'h0000);
    cmp(overflowFlag, 16'h0001);
    cmp(interruptRequest, 16'h0001);
    wrCount(16'h1233);
    cntFall();
    capFall();
    cmp(reload, 16'h1234);
    cmp(externalFlag, 16'h0001);
    clrFlags();
    cmp({overflowFlag, externalFlag, interruptRequest}, 16'h0000);
    $display("test capture done");
    // Prescaler table: fast, fast with apply, compatibility, doubled
    counterSelect = 1'b0;
    prescaleValue = 4'h3;
    for (int i = 0; i < 4; i++) begin
      runControl = 1'b0;
      fastMode = fastT[i][0];
      fastPrescaleApply = applyT[i][0];
      clrFlags();
      wrCount(16'hFFF0);
      runControl = 1'b1;
      waitOf();
      cmpIn(cyc, 15 * divT[i] - 1, 17 * divT[i] + 3);
    end
    fastMode = 1'b1;
    fastPrescaleApply = 1'b0;
    $display("test prescale done");
    // Auto-reload up, by overflow and by pin
    captureReloadSelect = 1'b0;
    counterSelect = 1'b1;
    wrReload(16'h1234);
    wrCount(16'hFFFF);
    clrFlags();
    cntFall();
    cmp(count, 16'h1234);
    cmp(overflowFlag, 16'h0001);
    wrCount(16'h0055);
    capFall();
    cmp(count, 16'h1234);
    cmp(externalFlag, 16'h0001);
    clrFlags();
    $display("test reload up done");
    // Up/down: pin low counts down to the boundary, then up past the top
    downCountEnable = 1'b1;
    capHold = 1'b1;
    capLevel = 1'b0;
    wrCount(16'h1235);
    cntFall();
    cmp(count, 16'h1234);
    cntFall();
    cmp(count, 16'hFFFF);
    cmp({overflowFlag, externalFlag}, 16'h0003);
    overflowFlagClear = 1'b1;
    step();
    overflowFlagClear = 1'b0;
    step(3);
    cmp(interruptRequest, 16'h0000);
    capLevel = 1'b1;
    cntFall();
    cmp(count, 16'h1234);
    cmp({overflowFlag, externalFlag}, 16'h0002);
    downCountEnable = 1'b0;
    capHold = 1'b0;
    clrFlags();
    $display("test up down done");
    // Receive baud from this timer, transmit from the other, clock-out alongside
    counterSelect = 1'b0;
    rxBaudSelect = 1'b1;
    clockOutEnable = 1'b1;
    wrReload(16'hFFFC);
    wrCount(16'hFFFC);
    watch(40);
    cmpIn(rx, 9, 11);
    cmpIn(tx, 4, 6);
    cmpIn(co, 9, 11);
    cmp({overflowFlag, interruptRequest}, 16'h0000);
    capFall();
    cmp(externalFlag, 16'h0001);
    rxBaudSelect = 1'b0;
    clrFlags();
    $display("test baud done");
    // Clock-out alone, then stopped by run control
    wrReload(16'hFFFB);
    watch(50);
    cmpIn(co, 9, 11);
    cmp(clockOutOeN, 16'h0000);
    cmp({overflowFlag, interruptRequest}, 16'h0000);
    runControl = 1'b0;
    step(2);
    watch(20);
    cmpIn(co, 0, 0);
    $display("test clock out done");
    summarize();
  end
endmodule

`default_nettype wire
